// [core/cax_pkg.sv]
// Shared constants, types and opcodes of the execution datapath
// What this block does
// - Sum and carry-sum write Rd; ZCNVH; one cycle
// - Word immediate sum on pair; ZCNVS; two cycles
// - Word immediate difference on pair; ZCNVS; two cycles
// - Register differences, borrow variant; ZCNVH; one cycle
// - Constant differences, borrow variant; ZCNVH; one cycle
// - Conjunction, register or constant; ZNV only; one cycle
// - Disjunctions and set-bits write Rd; ZNV; one cycle
// - Exclusive disjunction writes Rd; ZNV; one cycle
// - Clear-bits ANDs with 0xFF minus constant; ZNV
// - Zero-sign check ANDs register with itself; ZNV
// - Products go to R1:R0; ZC; two cycles
// - Fractional products shifted left once; ZC; two cycles
// - Pointer jump loads PC from Z; two cycles
// - Relative entry pushes, PC+k+1; three cycles
// - Pointer entry pushes, PC from Z; three cycles
// - Direct entry pushes, absolute target; four cycles
// - Compare-skip on equal, PC+2 or +3; 1/2/3 cycles
`default_nettype none
package cax_pkg;
  // Status register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_I = 7;
  // Flag update masks per instruction class
  localparam logic [7:0] FM_ARITH = 8'h2F;
  localparam logic [7:0] FM_WORD = 8'h1F;
  localparam logic [7:0] FM_LOGIC = 8'h0E;
  localparam logic [7:0] FM_PROD = 8'h03;
  localparam logic [7:0] FM_INT = 8'h80;
  localparam logic [7:0] FM_NONE = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  // Cycle counts
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  // Program counter steps
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [15:0] PC_STEP_LONG = 16'h0002;
  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0] RST_CNT = 3'h0;

  typedef enum logic [4:0] {
    OP_SUM, OP_SUM_CARRY, OP_WORD_SUM, OP_WORD_DIFF,
    OP_DIFF, OP_BORROW_DIFF, OP_CONST_DIFF, OP_CONST_BORROW_DIFF,
    OP_CONJ, OP_CONST_CONJ, OP_DISJ, OP_CONST_DISJ, OP_SET_BITS,
    OP_XDISJ, OP_CLEAR_BITS, OP_ZERO_SIGN,
    OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD, OP_FSPROD, OP_FMPROD,
    OP_PTR_JUMP, OP_REL_ENTRY, OP_PTR_ENTRY, OP_DIR_ENTRY,
    OP_LEAVE_SUB, OP_LEAVE_INT, OP_CMP_SKIP
  } cax_op_t;

  typedef enum logic {ST_IDLE, ST_RUN} cax_state_t;
endpackage
`default_nettype wire

// [core/cax_product.sv]
// Eight by eight multiplier with signed, mixed and fractional modes
`default_nettype none
module cax_product (
  // Operands
  input wire logic [7:0] mulA,
  input wire logic [7:0] mulB,
  // Mode
  input wire logic signA,
  input wire logic signB,
  input wire logic frac,
  // Product
  output logic [15:0] prodOut,
  output logic prodCarry
);
  logic signed [8:0] extA;
  logic signed [8:0] extB;
  logic signed [17:0] full;
  logic [15:0] raw;

  assign extA = {signA & mulA[7], mulA};
  assign extB = {signB & mulB[7], mulB};
  assign full = extA * extB;
  assign raw = full[15:0];
  // Carry is taken before the fractional shift
  assign prodCarry = raw[15];
  assign prodOut = frac ? {raw[14:0], 1'b0} : raw;
endmodule
`default_nettype wire

// [core/cax_exec_unit.sv]
// Execution datapath: arithmetic, logic, products and program flow
`default_nettype none
module cax_exec_unit
  import cax_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Instruction issue
  input wire logic start,
  input wire cax_op_t op,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic [7:0] imm,
  input wire logic [15:0] wordIn,
  input wire logic [15:0] zPtr,
  input wire logic [15:0] pcIn,
  input wire logic [11:0] relOff,
  input wire logic [15:0] absTarget,
  input wire logic nextTwoWord,
  input wire logic [15:0] popAddr,
  input wire logic [7:0] sregIn,
  // Completion
  output logic busy,
  output logic done,
  // Register file write back
  output logic resWe,
  output logic [7:0] resData,
  output logic pairWe,
  output logic pairSel,
  output logic [15:0] pairData,
  // Status register
  output logic sregWe,
  output logic [7:0] sregOut,
  // Program counter and stack
  output logic pcWe,
  output logic [15:0] pcOut,
  output logic pushWe,
  output logic [15:0] pushAddr,
  output logic popReq
);
  function automatic logic [7:0] packFlags(
    input logic h, input logic s, input logic v,
    input logic n, input logic z, input logic c);
    packFlags = {2'b00, h, s, v, n, z, c};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Control state

  cax_state_t state_r;
  cax_state_t stateNxt;
  logic [2:0] cnt_r;
  logic [2:0] cntNxt;
  logic take;
  logic [2:0] cycN;

  // A new instruction may issue in the cycle the previous one ends
  assign take = start && ((state_r == ST_IDLE) || done);
  assign done = (state_r == ST_RUN) && (cnt_r == RST_CNT);
  assign busy = (state_r == ST_RUN) && !done;
  assign stateNxt = take ? ST_RUN : (done ? ST_IDLE : state_r);
  assign cntNxt = take ? cycN - CYC_ONE : (done ? cnt_r : cnt_r - CYC_ONE);

  ////////////////////////////////////////////////////////////////////
  // Operand selection

  logic isConst;
  logic useCarry;
  logic [7:0] srcB;
  logic cin;

  assign isConst = op inside {OP_CONST_DIFF, OP_CONST_BORROW_DIFF,
    OP_CONST_CONJ, OP_CONST_DISJ, OP_SET_BITS, OP_CLEAR_BITS};
  assign useCarry = op inside {OP_SUM_CARRY, OP_BORROW_DIFF,
    OP_CONST_BORROW_DIFF};
  assign srcB = isConst ? imm : opB;
  assign cin = useCarry & sregIn[FLG_C];

  ////////////////////////////////////////////////////////////////////
  // Byte sum and difference

  logic [8:0] sumW;
  logic [8:0] diffW;
  logic [7:0] sumR;
  logic [7:0] diffR;
  logic sumH;
  logic sumV;
  logic diffH;
  logic diffV;
  logic diffZ;

  assign sumW = {1'b0, opA} + {1'b0, srcB} + {8'h00, cin};
  assign diffW = {1'b0, opA} - {1'b0, srcB} - {8'h00, cin};
  assign sumR = sumW[7:0];
  assign diffR = diffW[7:0];
  assign sumH = (opA[3] & srcB[3]) | (srcB[3] & ~sumR[3]) | (~sumR[3] & opA[3]);
  assign sumV = (opA[7] & srcB[7] & ~sumR[7]) | (~opA[7] & ~srcB[7] & sumR[7]);
  assign diffH = (~opA[3] & srcB[3]) | (srcB[3] & diffR[3]) | (diffR[3] & ~opA[3]);
  assign diffV = (opA[7] & ~srcB[7] & ~diffR[7]) | (~opA[7] & srcB[7] & diffR[7]);
  // Borrow forms keep zero only if the earlier byte was zero too
  assign diffZ = (diffR == RST_BYTE) & (!useCarry | sregIn[FLG_Z]);

  ////////////////////////////////////////////////////////////////////
  // Bitwise results

  logic isConj;
  logic [7:0] logicR;

  assign isConj = op inside {OP_CONJ, OP_CONST_CONJ};
  assign logicR = isConj ? (opA & srcB) :
    (op == OP_ZERO_SIGN) ? (opA & opA) :
    (op == OP_XDISJ) ? (opA ^ opB) :
    (op == OP_CLEAR_BITS) ? (opA & (MASK_FULL - imm)) :
    (opA | srcB);

  ////////////////////////////////////////////////////////////////////
  // Word immediate on a register pair

  logic wordSub;
  logic [15:0] wordR;
  logic wordV;
  logic wordC;

  assign wordSub = (op == OP_WORD_DIFF);
  assign wordR = wordSub ? wordIn - {8'h00, imm} : wordIn + {8'h00, imm};
  assign wordV = wordSub ? (wordIn[15] & ~wordR[15]) : (~wordIn[15] & wordR[15]);
  assign wordC = wordSub ? (wordR[15] & ~wordIn[15]) : (~wordR[15] & wordIn[15]);

  ////////////////////////////////////////////////////////////////////
  // Products

  logic [15:0] prodR;
  logic prodC;
  logic prodSignA;
  logic prodSignB;
  logic prodFrac;

  assign prodSignA = op inside {OP_SPROD, OP_MPROD, OP_FSPROD, OP_FMPROD};
  assign prodSignB = op inside {OP_SPROD, OP_FSPROD};
  assign prodFrac = op inside {OP_FUPROD, OP_FSPROD, OP_FMPROD};

  cax_product uProduct (
    .mulA(opA),
    .mulB(opB),
    .signA(prodSignA),
    .signB(prodSignB),
    .frac(prodFrac),
    .prodOut(prodR),
    .prodCarry(prodC)
  );

  ////////////////////////////////////////////////////////////////////
  // Program flow targets

  logic [15:0] relTarget;
  logic [15:0] nextPc;
  logic isEqual;
  logic [15:0] skipStep;
  logic [2:0] skipCyc;

  assign nextPc = pcIn + PC_STEP_ONE;
  assign relTarget = nextPc + {{4{relOff[11]}}, relOff};
  assign isEqual = (opA == opB);
  assign skipStep = !isEqual ? PC_STEP_ONE :
    (nextTwoWord ? PC_SKIP_TWO : PC_SKIP_ONE);
  assign skipCyc = !isEqual ? CYC_ONE : (nextTwoWord ? CYC_THREE : CYC_TWO);

  ////////////////////////////////////////////////////////////////////
  // Per-operation decode

  logic [7:0] resN;
  logic resWeN;
  logic [15:0] pairN;
  logic pairWeN;
  logic pairSelN;
  logic [7:0] flagN;
  logic [7:0] maskN;
  logic [15:0] pcN;
  logic pcWeN;
  logic [15:0] pushN;
  logic pushWeN;
  logic popN;

  always_comb begin
    resN = logicR;
    resWeN = 1'b0;
    pairN = prodR;
    pairWeN = 1'b0;
    pairSelN = 1'b0;
    flagN = packFlags(1'b0, 1'b0, 1'b0, logicR[7], logicR == RST_BYTE, 1'b0);
    maskN = FM_NONE;
    cycN = CYC_ONE;
    pcN = nextPc;
    pcWeN = 1'b0;
    pushN = nextPc;
    pushWeN = 1'b0;
    popN = 1'b0;
    unique case (op)
      OP_SUM, OP_SUM_CARRY: begin
        resN = sumR;
        resWeN = 1'b1;
        flagN = packFlags(sumH, 1'b0, sumV, sumR[7], sumR == RST_BYTE, sumW[8]);
        maskN = FM_ARITH;
      end
      OP_DIFF, OP_BORROW_DIFF, OP_CONST_DIFF, OP_CONST_BORROW_DIFF: begin
        resN = diffR;
        resWeN = 1'b1;
        flagN = packFlags(diffH, 1'b0, diffV, diffR[7], diffZ, diffW[8]);
        maskN = FM_ARITH;
      end
      OP_WORD_SUM, OP_WORD_DIFF: begin
        pairN = wordR;
        pairWeN = 1'b1;
        pairSelN = 1'b1;
        flagN = packFlags(1'b0, wordR[15] ^ wordV, wordV, wordR[15],
          wordR == RST_WORD, wordC);
        maskN = FM_WORD;
        cycN = CYC_TWO;
      end
      OP_CONJ, OP_CONST_CONJ, OP_DISJ, OP_CONST_DISJ, OP_SET_BITS,
      OP_XDISJ, OP_CLEAR_BITS: begin
        resWeN = 1'b1;
        maskN = FM_LOGIC;
      end
      OP_ZERO_SIGN: begin
        resWeN = 1'b1;
        maskN = FM_LOGIC;
      end
      OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD, OP_FSPROD, OP_FMPROD: begin
        pairWeN = 1'b1;
        flagN = packFlags(1'b0, 1'b0, 1'b0, 1'b0, prodR == RST_WORD, prodC);
        maskN = FM_PROD;
        cycN = CYC_TWO;
      end
      OP_PTR_JUMP: begin
        pcN = zPtr;
        pcWeN = 1'b1;
        cycN = CYC_TWO;
      end
      OP_REL_ENTRY: begin
        pcN = relTarget;
        pcWeN = 1'b1;
        pushWeN = 1'b1;
        cycN = CYC_THREE;
      end
      OP_PTR_ENTRY: begin
        pcN = zPtr;
        pcWeN = 1'b1;
        pushWeN = 1'b1;
        cycN = CYC_THREE;
      end
      OP_DIR_ENTRY: begin
        pcN = absTarget;
        pcWeN = 1'b1;
        pushN = pcIn + PC_STEP_LONG;
        pushWeN = 1'b1;
        cycN = CYC_FOUR;
      end
      OP_LEAVE_SUB, OP_LEAVE_INT: begin
        pcN = popAddr;
        pcWeN = 1'b1;
        popN = 1'b1;
        flagN = MASK_FULL;
        maskN = (op == OP_LEAVE_INT) ? FM_INT : FM_NONE;
        cycN = CYC_FOUR;
      end
      OP_CMP_SKIP: begin
        pcN = pcIn + skipStep;
        pcWeN = 1'b1;
        cycN = skipCyc;
      end
      default: begin
        resWeN = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Result registers

  logic resWe_r;
  logic pairWe_r;
  logic sregWe_r;
  logic pcWe_r;
  logic pushWe_r;
  logic pop_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= RST_CNT;
    end else begin
      state_r <= stateNxt;
      cnt_r <= cntNxt;
    end
  end

  // Results held stable until the next issue
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {resWe_r, pairWe_r, sregWe_r, pcWe_r, pushWe_r, pop_r} <= 6'h00;
      resData <= RST_BYTE;
      pairData <= RST_WORD;
      pairSel <= 1'b0;
      sregOut <= RST_BYTE;
      pcOut <= RST_WORD;
      pushAddr <= RST_WORD;
    end else if (take) begin
      {resWe_r, pairWe_r, pcWe_r, pushWe_r, pop_r} <=
        {resWeN, pairWeN, pcWeN, pushWeN, popN};
      sregWe_r <= (maskN != FM_NONE);
      resData <= resN;
      pairData <= pairN;
      pairSel <= pairSelN;
      sregOut <= (sregIn & ~maskN) | (flagN & maskN);
      pcOut <= pcN;
      pushAddr <= pushN;
    end
  end

  // Strobes fire only in the closing cycle
  assign resWe = done & resWe_r;
  assign pairWe = done & pairWe_r;
  assign sregWe = done & sregWe_r;
  assign pcWe = done & pcWe_r;
  assign pushWe = done & pushWe_r;
  assign popReq = done & pop_r;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  chk_sum_one_cycle: assert property (
    take && op == OP_SUM |-> ##1 done && resWe &&
      resData == 8'($past(opA) + $past(opB)))
    else $error("sum result or timing wrong");

  chk_word_two_cycles: assert property (
    take && op inside {OP_WORD_SUM, OP_WORD_DIFF} |->
      ##1 !done ##1 done && pairWe && pairSel)
    else $error("word operation timing wrong");

  chk_diff_borrow: assert property (
    take && op == OP_DIFF |-> ##1 sregWe && sregOut[FLG_C] == ($past(opB) > $past(opA)))
    else $error("difference borrow flag wrong");

  chk_logic_flags: assert property (
    take && op inside {OP_CONJ, OP_DISJ, OP_CONST_DISJ} |-> ##1 done &&
      !sregOut[FLG_V] && sregOut[FLG_C] == $past(sregIn[FLG_C]))
    else $error("bitwise flags wrong");

  chk_clear_mask: assert property (
    take && op == OP_CLEAR_BITS |-> ##1 resData == ($past(opA) & ~$past(imm)))
    else $error("clear-bits result wrong");

  chk_prod_pair: assert property (
    take && op == OP_UPROD |-> ##1 !done ##1 done && pairWe && !pairSel &&
      pairData == 16'({8'h00, $past(opA, 2)} * {8'h00, $past(opB, 2)}))
    else $error("unsigned product wrong");

  chk_ptr_jump: assert property (
    take && op == OP_PTR_JUMP |-> ##1 !done ##1 done && pcWe && pcOut == $past(zPtr, 2))
    else $error("pointer jump wrong");

  chk_dir_entry: assert property (
    take && op == OP_DIR_ENTRY |-> ##1 (!done) [*3] ##1 done && pushWe &&
      pcOut == $past(absTarget, 4))
    else $error("direct entry wrong");

  chk_skip_miss: assert property (
    take && op == OP_CMP_SKIP && opA != opB |-> ##1 done && pcWe &&
      pcOut == $past(pcIn) + PC_STEP_ONE)
    else $error("compare-skip miss wrong");

  chk_leave_int: assert property (
    take && op == OP_LEAVE_INT |-> ##4 done && popReq && sregWe && sregOut[FLG_I])
    else $error("interrupt return wrong");

  cov_product: cover property (take && op == OP_FSPROD ##2 done);
  cov_long_skip: cover property (take && op == OP_CMP_SKIP && isEqual && nextTwoWord);
  cov_back_to_back: cover property (done && take);
endmodule
`default_nettype wire

// [verif/cax_far_model.sv]
// Return stack model on the far side of the execution datapath
`default_nettype none
module cax_far_model (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Stack traffic
  input wire logic pushWe,
  input wire logic [15:0] pushAddr,
  input wire logic popReq,
  output logic [15:0] popAddr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] stk_r [4];
  logic [1:0] sp_r;
  logic [15:0] lastPop_r;
  // Empty stack shows the inverse of the last pop, never a stale copy
  assign popAddr = (sp_r == 2'h0) ? ~lastPop_r : stk_r[sp_r - 2'h1];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sp_r <= 2'h0;
      lastPop_r <= 16'h0000;
    end else if (pushWe) begin
      stk_r[sp_r] <= pushAddr;
      sp_r <= sp_r + 2'h1;
    end else if (popReq) begin
      lastPop_r <= popAddr;
      sp_r <= sp_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_cpu_alu_branch_exec.sv]
// Self-checking bench for the execution datapath
`default_nettype none
module tb_cpu_alu_branch_exec
  import cax_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, arst_n = 1'b0, start = 1'b0, nextTwoWord = 1'b0;
  cax_op_t op = OP_SUM;
  logic [7:0] opA = 8'h00, opB = 8'h00, imm = 8'h00, sregIn = 8'h00;
  logic [15:0] wordIn = 16'h0000, zPtr = 16'h0000, pcIn = 16'h0000, absTarget = 16'h0000;
  logic [11:0] relOff = 12'h000;
  logic [7:0] resData, sregOut;
  logic [15:0] popAddr, pairData, pcOut, pushAddr;
  logic busy, done, resWe, pairWe, pairSel, sregWe, pcWe, pushWe, popReq;
  logic [5:0] strb;
  int n_fail, check_count, tick;
  assign strb = {resWe, sregWe, pairWe, pcWe, pushWe, popReq};

  cax_exec_unit dut (.clock(clock), .arst_n(arst_n), .start(start), .op(op), .opA(opA),
    .opB(opB), .imm(imm), .wordIn(wordIn), .zPtr(zPtr), .pcIn(pcIn), .relOff(relOff),
    .absTarget(absTarget), .nextTwoWord(nextTwoWord), .popAddr(popAddr), .sregIn(sregIn),
    .busy(busy), .done(done), .resWe(resWe), .resData(resData), .pairWe(pairWe),
    .pairSel(pairSel), .pairData(pairData), .sregWe(sregWe), .sregOut(sregOut),
    .pcWe(pcWe), .pcOut(pcOut), .pushWe(pushWe), .pushAddr(pushAddr), .popReq(popReq));
  cax_far_model far (.clock(clock), .arst_n(arst_n), .pushWe(pushWe),
    .pushAddr(pushAddr), .popReq(popReq), .popAddr(popAddr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Count edges after the take edge until done is sampled; busy must cover the gap
  task automatic await(inout int cyc);
    do begin
      @(posedge clock);
      cyc++;
      if (done !== 1'b1) chk({15'h0000, busy}, 16'h0001);
    end while (done !== 1'b1 && cyc < 8);
  endtask

  task automatic run(input cax_op_t o, input logic [7:0] a, b, k, output int cyc);
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    opA <= a;
    opB <= b;
    imm <= k;
    @(posedge clock);
    start <= 1'b0;
    cyc = 0;
    await(cyc);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] expByte(cax_op_t o, logic [7:0] a, b, k, s);
    logic [7:0] y, r, x, rr, yv;
    logic sub, h, c, v, z;
    y = (o inside {OP_CONST_DIFF, OP_CONST_BORROW_DIFF, OP_CONST_CONJ, OP_CONST_DISJ,
      OP_SET_BITS}) ? k : (o == OP_CLEAR_BITS) ? 8'hFF - k : b;
    sub = o inside {OP_DIFF, OP_BORROW_DIFF, OP_CONST_DIFF, OP_CONST_BORROW_DIFF};
    case (o)
      OP_SUM: r = a + y;
      OP_SUM_CARRY: r = a + y + s[0];
      OP_DIFF, OP_CONST_DIFF: r = a - y;
      OP_BORROW_DIFF, OP_CONST_BORROW_DIFF: r = a - y - s[0];
      OP_DISJ, OP_CONST_DISJ, OP_SET_BITS: r = a | y;
      OP_XDISJ: r = a ^ y;
      default: r = a & y;
    endcase
    // Subtraction carries are the sum forms with minuend and result inverted
    x = sub ? ~a : a;
    rr = sub ? ~r : r;
    yv = sub ? ~y : y;
    h = x[3] & y[3] | y[3] & ~rr[3] | ~rr[3] & x[3];
    c = x[7] & y[7] | y[7] & ~rr[7] | ~rr[7] & x[7];
    v = a[7] & yv[7] & ~r[7] | ~a[7] & ~yv[7] & r[7];
    z = (r == 8'h00) && (s[1] || !(o inside {OP_BORROW_DIFF, OP_CONST_BORROW_DIFF}));
    if (!(sub || o inside {OP_SUM, OP_SUM_CARRY})) return {r, s[7:4], 1'b0, r[7], z, s[0]};
    return {r, s[7:6], h, s[4], v, r[7], z, c};
  endfunction

  task automatic t_byte;
    logic [7:0] av [3] = '{8'h0F, 8'h80, 8'h7F};
    logic [7:0] bv [3] = '{8'h01, 8'h80, 8'h7F};
    logic [7:0] kv [3] = '{8'h11, 8'h80, 8'hFF};
    logic [7:0] sv [3] = '{8'hA4, 8'h03, 8'h40};
    logic [7:0] b;
    int cyc;
    cax_op_t o;
    for (int j = 0; j < 3; j++) begin
      for (int i = 0; i < 16; i++) begin
        if (i == 2 || i == 3) continue;
        o = cax_op_t'(i);
        b = (o == OP_ZERO_SIGN) ? av[j] : bv[j];
        sregIn <= sv[j];
        run(o, av[j], b, kv[j], cyc);
        chk(16'(cyc), 16'h0001);
        chk({resData, sregOut}, expByte(o, av[j], b, kv[j], sv[j]));
        chk({10'h000, strb}, 16'h0030);
      end
    end
    $display("byte operations finished");
  endtask

  task automatic t_word;
    logic [15:0] w, r;
    logic [7:0] k;
    logic sub, v, c;
    int cyc;
    for (int i = 0; i < 4; i++) begin
      sub = i[1];
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h7FC1 : (i == 2) ? 16'h0000 : 16'h8000;
      k = (i == 1) ? 8'h3F : 8'h01;
      r = sub ? w - {8'h00, k} : w + {8'h00, k};
      v = sub ? w[15] & ~r[15] : ~w[15] & r[15];
      c = sub ? r[15] & ~w[15] : ~r[15] & w[15];
      wordIn <= w;
      sregIn <= 8'hE0;
      run(sub ? OP_WORD_DIFF : OP_WORD_SUM, 8'h00, 8'h00, k, cyc);
      chk(16'(cyc), 16'h0002);
      chk(pairData, r);
      chk({8'h00, sregOut}, {11'h007, r[15] ^ v, v, r[15], r == 16'h0000, c});
      chk({9'h000, strb, pairSel}, 16'h0031);
    end
    $display("word operations finished");
  endtask

  task automatic t_prod;
    logic [7:0] a, b;
    logic signed [17:0] p;
    logic [15:0] r;
    int cyc;
    cax_op_t o;
    for (int i = 16; i < 22; i++) begin
      for (int j = 0; j < 3; j++) begin
        o = cax_op_t'(i);
        a = (j == 0) ? 8'hFF : (j == 1) ? 8'h80 : 8'h40;
        b = (j == 2) ? 8'h00 : a;
        p = $signed({(o inside {OP_SPROD, OP_MPROD, OP_FSPROD, OP_FMPROD}) & a[7], a})
          * $signed({(o inside {OP_SPROD, OP_FSPROD}) & b[7], b});
        r = (i > 18) ? {p[14:0], 1'b0} : p[15:0];
        sregIn <= 8'hFC;
        run(o, a, b, 8'h00, cyc);
        chk(16'(cyc), 16'h0002);
        chk(pairData, r);
        chk({8'h00, sregOut}, {8'h00, 6'h3F, r == 16'h0000, p[15]});
        chk({9'h000, strb, pairSel}, 16'h0030);
      end
    end
    $display("products finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic flow(input cax_op_t o, input logic [7:0] b, input logic two,
      input logic [15:0] cy, pc, push, input logic [5:0] st);
    int cyc;
    nextTwoWord <= two;
    run(o, 8'h5A, b, 8'h00, cyc);
    chk(16'(cyc), cy);
    chk(pcOut, pc);
    chk({10'h000, strb}, {10'h000, st});
    if (st[1]) chk(pushAddr, push);
    if (st[4]) chk({8'h00, sregOut}, 16'h0095);
  endtask

  task automatic t_flow;
    pcIn <= 16'h0100;
    zPtr <= 16'h2468;
    relOff <= 12'hFFE;
    absTarget <= 16'h3C00;
    sregIn <= 8'h15;
    flow(OP_PTR_JUMP, 8'h00, 1'b0, 16'h2, 16'h2468, 16'h0, 6'h04);
    flow(OP_REL_ENTRY, 8'h00, 1'b0, 16'h3, 16'h00FF, 16'h0101, 6'h06);
    flow(OP_LEAVE_SUB, 8'h00, 1'b0, 16'h4, 16'h0101, 16'h0, 6'h05);
    flow(OP_PTR_ENTRY, 8'h00, 1'b0, 16'h3, 16'h2468, 16'h0101, 6'h06);
    flow(OP_DIR_ENTRY, 8'h00, 1'b0, 16'h4, 16'h3C00, 16'h0102, 6'h06);
    flow(OP_LEAVE_INT, 8'h00, 1'b0, 16'h4, 16'h0102, 16'h0, 6'h15);
    flow(OP_LEAVE_SUB, 8'h00, 1'b0, 16'h4, 16'h0101, 16'h0, 6'h05);
    flow(OP_CMP_SKIP, 8'h5B, 1'b1, 16'h1, 16'h0101, 16'h0, 6'h04);
    flow(OP_CMP_SKIP, 8'h5A, 1'b0, 16'h2, 16'h0102, 16'h0, 6'h04);
    flow(OP_CMP_SKIP, 8'h5A, 1'b1, 16'h3, 16'h0103, 16'h0, 6'h04);
    $display("program flow finished");
  endtask

  // A request held up while busy must leave no trace: no extra done, no extra push
  task automatic t_refuse;
    int cyc;
    @(posedge clock);
    start <= 1'b1;
    op <= OP_DIR_ENTRY;
    @(posedge clock);
    op <= OP_PTR_JUMP;
    @(posedge clock);
    start <= 1'b0;
    cyc = 1;
    await(cyc);
    chk(16'(cyc), 16'h0004);
    chk(pcOut, 16'h3C00);
    repeat (5) begin
      @(posedge clock);
      chk({15'h0000, done}, 16'h0000);
    end
    flow(OP_LEAVE_SUB, 8'h00, 1'b0, 16'h4, 16'h0102, 16'h0, 6'h05);
    $display("refused request finished");
  endtask

  // Second start lands on the first one's done and must be taken there
  task automatic t_back;
    @(posedge clock);
    start <= 1'b1;
    op <= OP_SUM;
    opA <= 8'h21;
    opB <= 8'h12;
    @(posedge clock);
    op <= OP_CONJ;
    @(posedge clock);
    chk({14'h0000, done, resWe}, 16'h0003);
    chk({8'h00, resData}, 16'h0033);
    start <= 1'b0;
    @(posedge clock);
    chk({14'h0000, done, resWe}, 16'h0003);
    chk({8'h00, resData}, 16'h0000);
    $display("back to back finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clock = ~clock;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    tick++;
    if (tick == 3000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_byte();
    t_word();
    t_prod();
    t_flow();
    t_refuse();
    t_back();
    results();
  end
endmodule
`default_nettype wire
